// ---- hdl/hicpa_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hicpa_defs.vh"
module hicpa_top
(
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Fabric CSR write engine
  output reg         fab_req,
  output reg  [15:0] fab_csr_num,
  output reg  [3:0]  fab_byte_lanes,
  output reg  [31:0] fab_wdata,
  input  wire        fab_done,
  // PHY management engine
  output reg         phy_req,
  output reg         phy_write_select,
  output reg  [4:0]  phy_select,
  output reg  [4:0]  phy_reg_index,
  output reg  [15:0] phy_wdata,
  input  wire        phy_done,
  input  wire [15:0] phy_rdata
);
  // ==========================================================
  // Address phase capture
  // Writes are decoded one cycle late, in their data phase, since hwdata
  // only arrives then; the address waits in addr_q for that cycle.
  // hsize is not decoded: every register is one whole word.
  reg        wr_pend_q;
  reg [11:0] addr_q;
  wire       take = hsel & hready & htrans[1];
  wire [15:0] win_csr;
  wire        win_hit;
  hicpa_win_map u_map
  (
    .addr    (addr_q),
    .csr_num (win_csr),
    .hit     (win_hit)
  );
  // ==========================================================
  // Register state
  // Fabric command register contents
  reg        cmd_busy_q;
  reg        cmd_rnw_q;
  reg [3:0]  cmd_be_q;
  reg [15:0] cmd_csr_q;
  // PHY data register: host copy and returned word
  reg [15:0] host_data_q;
  reg [15:0] phy_ret_q;
  // PHY access register
  reg        acc_busy_q;
  reg        acc_wsel_q;
  reg [4:0]  acc_psel_q;
  reg [4:0]  acc_idx_q;
  wire wr_data = wr_pend_q & (addr_q == `HICPA_PHY_DATA_OFS);
  wire wr_acc  = wr_pend_q & (addr_q == `HICPA_PHY_ACCESS_OFS);
  // Window writes while a fabric write is pending are dropped to avoid overrun
  wire wr_win  = wr_pend_q & win_hit & ~cmd_busy_q;
  // Busy guards both PHY registers; the host is expected to poll first
  wire wr_data_ok = wr_data & ~acc_busy_q;
  wire wr_acc_ok  = wr_acc & ~acc_busy_q;
  // ==========================================================
  // Read data path
  // The word is picked in the address phase and registered at its edge,
  // so it stands in hrdata for the whole data phase from a flip-flop.
  // A write whose data phase overlaps this address phase lands on the
  // same edge; the busy bits include that launch, so a poll issued
  // right after a launch never reads a stale idle status.
  // Limitation: the other fields of such a read show the older contents.
  wire [11:0] rd_addr  = {haddr[11:2], 2'b00};
  wire        rd_take  = take & ~hwrite;
  wire        acc_busy = acc_busy_q | wr_acc_ok;
  wire        cmd_busy = cmd_busy_q | wr_win;
  reg  [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      `HICPA_PHY_DATA_OFS:
        rd_mux = {16'h0000, acc_wsel_q ? host_data_q : phy_ret_q};
      `HICPA_PHY_ACCESS_OFS:
        rd_mux = {16'h0000, acc_psel_q, acc_idx_q, 4'h0, acc_wsel_q, acc_busy};
      `HICPA_FAB_CMD_OFS:
        rd_mux = {cmd_busy, cmd_rnw_q, 10'h000, cmd_be_q, cmd_csr_q};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end
  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  // hreadyout and hresp are fixed after reset: every access completes at once
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      if (take)
        addr_q <= {haddr[11:2], 2'b00};
      // Read data stands for one data phase only, zero otherwise
      if (rd_take)
        hrdata <= rd_mux;
      else
        hrdata <= 32'h0000_0000;
    end
  end
  // ==========================================================
  // Fabric command register and request
  // The request is a one-cycle pulse; number, lanes and data stay
  // registered until the next launch so the engine may take them late.
  // Pending clears only on the engine's completion pulse; a window write
  // that meets pending is dropped, not queued, as there is no buffer.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_busy_q     <= 1'b0;
      cmd_rnw_q      <= 1'b0;
      cmd_be_q       <= 4'h0;
      cmd_csr_q      <= `HICPA_CSR_RST;
      fab_req        <= 1'b0;
      fab_csr_num    <= 16'h0000;
      fab_byte_lanes <= 4'h0;
      fab_wdata      <= 32'h0000_0000;
    end
    else
    begin
      fab_req <= 1'b0;
      if (wr_win)
      begin
        cmd_csr_q      <= win_csr;
        cmd_be_q       <= 4'hF;
        cmd_rnw_q      <= 1'b0;
        cmd_busy_q     <= 1'b1;
        fab_req        <= 1'b1;
        fab_csr_num    <= win_csr;
        fab_byte_lanes <= 4'hF;
        fab_wdata      <= hwdata;
      end
      else if (fab_done)
        cmd_busy_q <= 1'b0;
    end
  end
  // ==========================================================
  // PHY data and access registers
  // The launch copies the host data word into phy_wdata, so the value the
  // engine sees stays valid until busy clears; data writes are also
  // refused while busy.
  // The returned word is latched only for a read access and only on the
  // completion pulse, so the engine's data bus may carry anything otherwise.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      host_data_q      <= `HICPA_DATA_RST;
      phy_ret_q        <= `HICPA_DATA_RST;
      acc_busy_q       <= 1'b0;
      acc_wsel_q       <= 1'b0;
      acc_psel_q       <= 5'h00;
      acc_idx_q        <= 5'h00;
      phy_req          <= 1'b0;
      phy_write_select <= 1'b0;
      phy_select       <= 5'h00;
      phy_reg_index    <= 5'h00;
      phy_wdata        <= 16'h0000;
    end
    else
    begin
      phy_req <= 1'b0;
      if (wr_data_ok)
        host_data_q <= hwdata[15:0];
      if (wr_acc_ok)
      begin
        acc_psel_q       <= hwdata[`HICPA_PSEL_MSB:`HICPA_PSEL_LSB];
        acc_idx_q        <= hwdata[`HICPA_IDX_MSB:`HICPA_IDX_LSB];
        acc_wsel_q       <= hwdata[`HICPA_WSEL_BIT];
        acc_busy_q       <= 1'b1;
        // Only the physical PHY engine is driven; no emulated PHY tap
        phy_req          <= 1'b1;
        phy_write_select <= hwdata[`HICPA_WSEL_BIT];
        phy_select       <= hwdata[`HICPA_PSEL_MSB:`HICPA_PSEL_LSB];
        phy_reg_index    <= hwdata[`HICPA_IDX_MSB:`HICPA_IDX_LSB];
        phy_wdata        <= host_data_q;
      end
      else if (phy_done & acc_busy_q)
      begin
        acc_busy_q <= 1'b0;
        if (!acc_wsel_q)
          phy_ret_q <= phy_rdata;
      end
    end
  end
endmodule // hicpa_top
`default_nettype wire

// ---- hdl/hicpa_defs.vh ----
`ifndef HICPA_DEFS_VH
`define HICPA_DEFS_VH
// ==========================================================
// Register byte offsets
`define HICPA_PHY_DATA_OFS    12'h0A4
`define HICPA_PHY_ACCESS_OFS  12'h0A8
`define HICPA_FAB_CMD_OFS     12'h0B0
`define HICPA_WIN_LO          12'h240
`define HICPA_WIN_HI          12'h2DC
// ==========================================================
// Access register fields
`define HICPA_BUSY_BIT        0
`define HICPA_WSEL_BIT        1
`define HICPA_IDX_LSB         6
`define HICPA_IDX_MSB         10
`define HICPA_PSEL_LSB        11
`define HICPA_PSEL_MSB        15
// ==========================================================
// Command register fields
`define HICPA_CMD_BUSY_BIT    31
`define HICPA_CMD_RNW_BIT     30
`define HICPA_CMD_BE_LSB      16
`define HICPA_CMD_BE_MSB      19
// ==========================================================
// Reset values
`define HICPA_DATA_RST        16'h0000
`define HICPA_CSR_RST         16'h0000
`endif

// ---- hdl/hicpa_win_map.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hicpa_defs.vh"
// ==========================================================
// Window address to fabric CSR number lookup
module hicpa_win_map
(
  // Window byte address
  input  wire [11:0] addr,
  // Fabric CSR number and hit
  output reg  [15:0] csr_num,
  output reg         hit
);
  always @*
  begin
    hit = 1'b1;
    case (addr)
      12'h240: csr_num = 16'h1802;
      12'h244: csr_num = 16'h1809;
      12'h248: csr_num = 16'h180B;
      12'h24C: csr_num = 16'h180C;
      12'h250: csr_num = 16'h1811;
      12'h254: csr_num = 16'h1812;
      12'h258: csr_num = 16'h1840;
      12'h25C: csr_num = 16'h1841;
      12'h260: csr_num = 16'h1842;
      12'h264: csr_num = 16'h1843;
      12'h268: csr_num = 16'h1845;
      12'h26C: csr_num = 16'h1846;
      12'h270: csr_num = 16'h1847;
      12'h274: csr_num = 16'h1848;
      12'h278: csr_num = 16'h1849;
      12'h27C: csr_num = 16'h184A;
      12'h280: csr_num = 16'h184B;
      12'h284: csr_num = 16'h184D;
      12'h288: csr_num = 16'h1855;
      12'h28C: csr_num = 16'h1856;
      12'h290: csr_num = 16'h1857;
      12'h294: csr_num = 16'h1880;
      12'h298: csr_num = 16'h1C00;
      12'h29C: csr_num = 16'h1C01;
      12'h2A0: csr_num = 16'h1C02;
      12'h2A4: csr_num = 16'h1C03;
      12'h2A8: csr_num = 16'h1C04;
      12'h2AC: csr_num = 16'h1C09;
      12'h2B0: csr_num = 16'h1C0A;
      12'h2B4: csr_num = 16'h1C0C;
      12'h2B8: csr_num = 16'h1C0D;
      12'h2BC: csr_num = 16'h1C0E;
      12'h2C0: csr_num = 16'h1C0F;
      12'h2C4: csr_num = 16'h1C10;
      12'h2C8: csr_num = 16'h1C11;
      12'h2CC: csr_num = 16'h1C12;
      12'h2D0: csr_num = 16'h1C13;
      12'h2D4: csr_num = 16'h1C14;
      12'h2D8: csr_num = 16'h1C15;
      12'h2DC: csr_num = 16'h1C20;
      default:
      begin
        csr_num = 16'h0000;
        hit     = 1'b0;
      end
    endcase
  end
endmodule // hicpa_win_map
`default_nettype wire

// ---- sim/hicpa_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checker
module hicpa_checker
(
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Engines
  input wire logic        fab_req,
  input wire logic [15:0] fab_csr_num,
  input wire logic [3:0]  fab_byte_lanes,
  input wire logic [31:0] fab_wdata,
  input wire logic        fab_done,
  input wire logic        phy_req,
  input wire logic        phy_done
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic fpend_q;
  logic ppend_q;
  wire  acc = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fpend_q <= 1'b0;
      ppend_q <= 1'b0;
    end
    else
    begin
      fpend_q <= fab_req | (fpend_q & ~fab_done);
      ppend_q <= phy_req | (ppend_q & ~phy_done);
    end
  a_win_launch: assert property (($past(acc & hwrite & haddr >= 12'h240 & haddr <= 12'h2DC)
    && !fpend_q && !fab_req) |=> fab_req) else $error("window write not launched");
  a_lanes_all: assert property (fab_req |-> fab_byte_lanes == 4'hF)
    else $error("byte lanes not all set");
  a_fab_data: assert property (fab_req |-> fab_wdata == $past(hwdata))
    else $error("fabric data differs");
  a_one_fab: assert property (fab_req |-> !fpend_q)
    else $error("fabric launch while pending");
  a_one_phy: assert property (phy_req |-> !ppend_q)
    else $error("phy launch while busy");
  a_map_swe: assert property (fab_req && $past(haddr, 2) == 12'h244 |-> fab_csr_num == 16'h1809)
    else $error("engine window map");
  a_map_bm: assert property (fab_req && $past(haddr, 2) == 12'h2DC |-> fab_csr_num == 16'h1C20)
    else $error("buffer window map");
  a_map_egr: assert property (fab_req && $past(haddr, 2) == 12'h2B8 |-> fab_csr_num == 16'h1C0D)
    else $error("egress window map");
  a_hi_zero: assert property ($past(acc & !hwrite & haddr == 12'h0A4) |-> hrdata[31:16] == 16'h0)
    else $error("phy data upper bits set");
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or error response");
endmodule // hicpa_checker
`default_nettype wire

// ---- sim/hicpa_engines.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Fabric and PHY engine model
module hicpa_engines
(
  // Clock, reset, answer delay
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [3:0]  dly,
  // Launches
  input  wire logic        fab_req,
  input  wire logic        phy_req,
  input  wire logic        phy_write_select,
  input  wire logic [15:0] phy_wdata,
  // Answers
  output logic             fab_done,
  output logic             phy_done,
  output logic [15:0]      phy_rdata
);
  logic [4:0]  fc_q;
  logic [4:0]  pc_q;
  logic [15:0] store_q;
  logic [15:0] junk_q;
  assign fab_done = (fc_q == 5'h01);
  assign phy_done = (pc_q == 5'h01);
  // Noise outside the done cycle so a stale sample shows up
  assign phy_rdata = phy_done ? ~store_q : junk_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fc_q <= 5'h00;
      pc_q <= 5'h00;
      store_q <= 16'h0000;
      junk_q <= 16'h0000;
    end
    else
    begin
      junk_q <= junk_q + 16'h3C5B;
      fc_q <= fab_req ? {1'b0, dly} + 5'h02 : fc_q - {4'h0, fc_q != 5'h00};
      pc_q <= phy_req ? {1'b0, dly} + 5'h02 : pc_q - {4'h0, pc_q != 5'h00};
      // Taken at completion: the data must still be held then
      if (phy_done && phy_write_select)
        store_q <= phy_wdata;
    end
endmodule // hicpa_engines
`default_nettype wire

// ---- sim/hicpa_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module hicpa_top_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  dly = 4'h2;
  wire  [31:0] hrdata, fab_wdata;
  wire  [15:0] fab_csr_num, phy_wdata, phy_rdata;
  wire  [4:0]  phy_select, phy_reg_index;
  wire  [3:0]  fab_byte_lanes;
  wire         hreadyout, hresp, fab_req, fab_done, phy_req, phy_write_select, phy_done;
  int          mismatches = 0;
  int          cmp_count = 0;
  integer      seed = 32'hA0D1F090;
  logic [63:0] rq[$];
  logic [31:0] lq[$];
  logic        rd_q = 1'b0;
  logic [31:0] r, v;
  logic [15:0] d, sv;
  logic [9:0]  pa;
  logic [11:0] wa [14] = '{12'h240, 12'h244, 12'h284, 12'h288, 12'h290, 12'h294, 12'h298,
                           12'h2B8, 12'h2BC, 12'h2C0, 12'h2C4, 12'h2C8, 12'h2CC, 12'h2DC};
  logic [15:0] wc [14] = '{16'h1802, 16'h1809, 16'h184D, 16'h1855, 16'h1857, 16'h1880, 16'h1C00,
                           16'h1C0D, 16'h1C0E, 16'h1C0F, 16'h1C10, 16'h1C11, 16'h1C12, 16'h1C20};
  always #4 hclk = ~hclk;
  hicpa_top hicpa_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fab_req(fab_req),
    .fab_csr_num(fab_csr_num), .fab_byte_lanes(fab_byte_lanes), .fab_wdata(fab_wdata),
    .fab_done(fab_done), .phy_req(phy_req), .phy_write_select(phy_write_select),
    .phy_select(phy_select), .phy_reg_index(phy_reg_index), .phy_wdata(phy_wdata),
    .phy_done(phy_done), .phy_rdata(phy_rdata));
  hicpa_engines hicpa_engines_inst (.hclk(hclk), .hresetn(hresetn), .dly(dly),
    .fab_req(fab_req), .phy_req(phy_req), .phy_write_select(phy_write_select),
    .phy_wdata(phy_wdata), .fab_done(fab_done), .phy_done(phy_done), .phy_rdata(phy_rdata));
  task automatic wrap_up(input int bad);
    mismatches += bad;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fail(input string s);
    mismatches++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic chk(input logic [31:0] got, input logic [63:0] e);
    cmp_count++;
    if ((got & e[63:32]) !== e[31:0]) fail("read data");
  endtask
  task automatic chk_req(input logic [31:0] got);
    cmp_count++;
    if (lq.size() == 0 || got !== lq.pop_front()) fail("engine launch");
  endtask
  task automatic edge_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) wrap_up(1);
  endtask
  // ====
  // Single AHB transfer; reads note masked expectation
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dv,
                      input logic [31:0] m, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    if (!w) rq.push_back({m, dv & m});
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dv;
    edge_rdy;
    rd = hrdata;
  endtask
  task automatic poll(input logic [11:0] a, input int b);
    logic [31:0] x;
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, a, 32'h0, 32'h0, x);
      n++;
    end
    while (x[b] !== 1'b0 && n < 40);
    if (x[b] !== 1'b0) wrap_up(1);
  endtask
  always @(posedge hclk)
  begin
    if (rd_q && hreadyout === 1'b1) chk(hrdata, rq.pop_front());
    if (hreadyout === 1'b1) rd_q <= hsel & htrans[1] & ~hwrite;
    if (fab_req === 1'b1) chk_req({16'h0, fab_csr_num});
    if (phy_req === 1'b1) chk_req({5'h0, phy_write_select, phy_select, phy_reg_index, phy_wdata});
  end
  initial
  begin
    sv = 16'h0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 12'h0A4, 32'h0, 32'hFFFFFFFF, r);
    xfer(1'b0, 12'h0A8, 32'h0, 32'hFFFFFFFF, r);
    xfer(1'b0, 12'h100, 32'h0, 32'hFFFFFFFF, r);
    for (int i = 0; i < 14; i++)
    begin
      v = $random(seed);
      dly <= {1'b0, v[2:0]} + 4'h2;
      lq.push_back({16'h0, wc[i]});
      xfer(1'b1, wa[i], v, 32'h0, r);
      @(posedge hclk);
      xfer(1'b0, 12'h0B0, 32'h800F0000 | wc[i], 32'hFFFFFFFF, r);
      poll(12'h0B0, 31);
    end
    // Second window write lands while the first is pending
    lq.push_back({16'h0, 16'h1809});
    xfer(1'b1, 12'h244, v, 32'h0, r);
    xfer(1'b1, 12'h2B8, v, 32'h0, r);
    poll(12'h0B0, 31);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      d = v[15:0];
      pa = v[25:16];
      xfer(1'b1, 12'h0A4, {16'h0, d}, 32'h0, r);
      lq.push_back({5'h0, i[0], pa, d});
      xfer(1'b1, 12'h0A8, {16'h0, pa, 4'h0, i[0], 1'b0}, 32'h0, r);
      xfer(1'b0, 12'h0A8, {16'h0, pa, 4'h0, i[0], 1'b1}, 32'hFFFFFFFF, r);
      xfer(1'b1, 12'h0A4, ~v, 32'h0, r);
      poll(12'h0A8, 0);
      if (i[0]) sv = d;
      xfer(1'b0, 12'h0A4, {16'h0, i[0] ? d : ~sv}, 32'hFFFFFFFF, r);
    end
    // Let the monitor take the last result before the verdict
    repeat (2) @(posedge hclk);
    if (rq.size() != 0 || lq.size() != 0) fail("results left unchecked");
    wrap_up(0);
  end
endmodule // hicpa_top_test
bind hicpa_top hicpa_checker hicpa_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fab_req(fab_req),
  .fab_csr_num(fab_csr_num),
  .fab_byte_lanes(fab_byte_lanes), .fab_wdata(fab_wdata), .fab_done(fab_done),
  .phy_req(phy_req), .phy_done(phy_done));
`default_nettype wire
